// File: rtl/cbd_cfg.svh
// constants for the branch, boolean and interrupt dispatch block
`ifndef CBD_CFG_SVH
`define CBD_CFG_SVH
`define CBD_NSRC 18
`define CBD_NGRP 8
`define CBD_EVW 4
`define CBD_AUTOCLR 18'h01e0f
`define CBD_LEVEL 18'h0a040
`define CBD_VEC_BASE 16'h0003
`define CBD_VEC_SHIFT 3
`define CBD_A_FLAG 8'h00
`define CBD_A_ENA 8'h04
`define CBD_A_ENB 8'h08
`define CBD_A_ENC 8'h0c
`define CBD_A_PRIO 8'h10
`define CBD_A_EVMASK 8'h14
`define CBD_A_STAT 8'h18
`define CBD_OP_JBC 8'h10
`define CBD_OP_COMPARE_JUMP_NOT_EQUAL_D 8'hb5
`define CBD_OP_COMPARE_JUMP_NOT_EQUAL_I 8'hb4
`define CBD_OP_COMPARE_JUMP_NOT_EQUAL_R 8'b1011_1???
`define CBD_OP_COMPARE_JUMP_NOT_EQUAL_N 8'b1011_011?
`define CBD_OP_DECREMENT_JUMP_NONZERO_R 8'b1101_1???
`define CBD_OP_DECREMENT_JUMP_NONZERO_D 8'hd5
`define CBD_OP_JZ 8'h60
`define CBD_OP_JNZ 8'h70
`define CBD_OP_JC 8'h40
`define CBD_OP_JNC 8'h50
`define CBD_OP_JB 8'h20
`define CBD_OP_JNB 8'h30
`define CBD_OP_JMPI 8'h73
`define CBD_OP_ANLC 8'h82
`define CBD_OP_ANLCN 8'hb0
`define CBD_OP_ORLC 8'h72
`define CBD_OP_ORLCN 8'ha0
`define CBD_OP_MOVCB 8'ha2
`define CBD_OP_MOVBC 8'h92
`define CBD_OP_ABSOLUTE_CALL 8'b???1_0001
`define CBD_OP_AJMP 8'b???0_0001
`define CBD_OP_LONG_CALL 8'h12
`define CBD_OP_RET 8'h22
`define CBD_OP_RETURN_FROM_IRQ 8'h32
`define CBD_OP_LJMP 8'h02
`define CBD_OP_SJMP 8'h80
`define CBD_OP_NOP 8'h00
`define CBD_OP_CLRC 8'hc3
`define CBD_OP_CLRB 8'hc2
`define CBD_OP_SETC 8'hd3
`define CBD_OP_SETB 8'hd2
`define CBD_OP_CPLC 8'hb3
`define CBD_OP_CPLB 8'hb2
`define CBD_OP_MUL 8'ha4
`define CBD_OP_DIV 8'h84
`define CBD_OP_DA 8'hd4
`define CBD_OP_RRC 8'h13
`define CBD_OP_RLC 8'h33
`define CBD_HI_ADD 4'h2
`define CBD_HI_ADDC 4'h3
`define CBD_HI_SUBB 4'h9
`endif

// File: rtl/cbd_pkg.sv
// types for the branch, boolean and interrupt dispatch block
package cbd_pkg;
	typedef struct packed {
		logic [1:0] len;
		logic [2:0] cyc;
		logic known;
		logic jump;
		logic cyWr;
		logic cyAlu;
		logic cyVal;
		logic ovWr;
		logic acWr;
		logic bitWr;
		logic bitVal;
		logic retIrq;
	} cbd_dec_t;
	typedef struct packed {
		logic opValid;
		logic [7:0] opcode;
		logic [7:0] acc;
		logic carry;
		logic bitIn;
		logic [7:0] opA;
		logic [7:0] opB;
		logic boundary;
	} cbd_cpu_t;
	typedef struct packed {
		logic [7:0] addr;
		logic write;
	} cbd_aphase_t;
	typedef enum logic [1:0] {BS_IDLE, BS_RWAIT, BS_RDONE} cbd_bus_t;
endpackage

// File: rtl/cbd_dispatch.sv
// branch and boolean decoder with interrupt dispatch, AHB-Lite registers
`timescale 1ns/1ns
`include "cbd_cfg.svh"
module cbd_dispatch #(
	parameter int NSRC = `CBD_NSRC,
	parameter int NGRP = `CBD_NGRP,
	parameter int EVW = `CBD_EVW
) (
	input wire logic clk_sys,
	input wire logic rst,
	input wire logic hsel,
	input wire logic [31:0] haddr,
	input wire logic [1:0] htrans,
	input wire logic hwrite,
	input wire logic [2:0] hsize,
	input wire logic [31:0] hwdata,
	input wire logic hready,
	output logic hreadyout,
	output logic hresp,
	output logic [31:0] hrdata,
	input wire logic [NSRC-1:0] srcReq,
	input wire logic [NGRP*EVW-1:0] evtReq,
	input wire cbd_pkg::cbd_cpu_t cpuIn,
	output logic irqCall,
	output logic [15:0] irqVector,
	output logic [4:0] irqNum,
	output logic decValid,
	output cbd_pkg::cbd_dec_t decOut
);
	localparam logic [NGRP-1:0][4:0] GRP_SRC = {5'd16, 5'd15, 5'd13, 5'd12, 5'd11, 5'd10, 5'd9, 5'd6};
	localparam logic [NSRC-1:0] AUTOCLR = `CBD_AUTOCLR;
	localparam logic [NSRC-1:0] LEVEL = `CBD_LEVEL;

	// =====================================================
	// bus slave
	cbd_pkg::cbd_bus_t bs_r;
	cbd_pkg::cbd_aphase_t ap_r;
	logic wrPend_r;
	logic [31:0] hrdata_r;
	logic aValid;
	logic wrNow;
	logic [NSRC-1:0] flags_r;
	logic [NSRC-1:0] en_r;
	logic gen_r;
	logic [NSRC-1:0] prio_r;
	logic [NGRP*EVW-1:0] evMask_r;
	logic [1:0] inSvc_r;
	logic irqCall_r;
	logic [15:0] irqVector_r;
	logic [4:0] irqNum_r;

	assign aValid = hsel && htrans[1] && hready && (bs_r != cbd_pkg::BS_RWAIT);
	assign wrNow = wrPend_r;
	assign hreadyout = (bs_r != cbd_pkg::BS_RWAIT);
	assign hresp = 1'b0;
	assign hrdata = hrdata_r;

	function automatic logic [31:0] regRead(input logic [7:0] a);
		logic [31:0] r;
		r = '0;
		case (a)
			`CBD_A_FLAG: r[NSRC-1:0] = flags_r;
			`CBD_A_ENA: r[7:0] = {gen_r, 1'b0, en_r[5:0]};
			`CBD_A_ENB: r[7:0] = {2'b00, en_r[13:8]};
			`CBD_A_ENC: r[7:0] = {2'b00, en_r[17], en_r[15], en_r[14], en_r[7], en_r[6], en_r[16]};
			`CBD_A_PRIO: r[NSRC-1:0] = prio_r;
			`CBD_A_EVMASK: r[NGRP*EVW-1:0] = evMask_r;
			`CBD_A_STAT: r[6:0] = {irqNum_r, inSvc_r};
			default: r = '0;
		endcase
		return r;
	endfunction

	always_ff @(posedge clk_sys or posedge rst) begin
		if (rst) begin
			bs_r <= cbd_pkg::BS_IDLE;
			ap_r <= '0;
			wrPend_r <= 1'b0;
		end else begin
			wrPend_r <= aValid && hwrite;
			if (aValid) begin
				ap_r <= '{addr: haddr[7:0], write: hwrite};
			end
			unique case (bs_r)
				cbd_pkg::BS_RWAIT: bs_r <= cbd_pkg::BS_RDONE;
				cbd_pkg::BS_IDLE, cbd_pkg::BS_RDONE: begin
					if (aValid && !hwrite) begin
						bs_r <= cbd_pkg::BS_RWAIT;
					end else begin
						bs_r <= cbd_pkg::BS_IDLE;
					end
				end
			endcase
		end
	end

	always_ff @(posedge clk_sys or posedge rst) begin
		if (rst) begin
			hrdata_r <= '0;
		end else if (bs_r == cbd_pkg::BS_RWAIT) begin
			hrdata_r <= regRead(ap_r.addr);
		end
	end

	// =====================================================
	// enables, priority and event masks
	always_ff @(posedge clk_sys or posedge rst) begin
		if (rst) begin
			en_r <= '0;
			gen_r <= 1'b0;
		end else if (wrNow) begin
			case (ap_r.addr)
				`CBD_A_ENA: begin
					en_r[5:0] <= hwdata[5:0];
					gen_r <= hwdata[7];
				end
				`CBD_A_ENB: en_r[13:8] <= hwdata[5:0];
				`CBD_A_ENC: begin
					{en_r[17], en_r[15], en_r[14], en_r[7], en_r[6], en_r[16]} <= hwdata[5:0];
				end
				default: ;
			endcase
		end
	end

	always_ff @(posedge clk_sys or posedge rst) begin
		if (rst) begin
			prio_r <= '0;
			evMask_r <= '0;
		end else if (wrNow) begin
			if (ap_r.addr == `CBD_A_PRIO) begin
				prio_r <= hwdata[NSRC-1:0];
			end
			if (ap_r.addr == `CBD_A_EVMASK) begin
				evMask_r <= hwdata[NGRP*EVW-1:0];
			end
		end
	end

	// =====================================================
	// request shaping and flags
	logic [NSRC-1:0] reqAll;
	logic [NSRC-1:0] reqD_r;
	logic [NSRC-1:0] setEv;
	logic [NSRC-1:0] flags_nxt;
	logic takeNow;
	logic [4:0] selNum;

	always_comb begin
		reqAll = srcReq;
		for (int g = 0; g < NGRP; g++) begin
			reqAll[GRP_SRC[g]] = |(evtReq[g*EVW +: EVW] & evMask_r[g*EVW +: EVW]);
		end
	end

	always_ff @(posedge clk_sys or posedge rst) begin
		if (rst) begin
			reqD_r <= '0;
		end else begin
			reqD_r <= reqAll;
		end
	end

	// ports follow the level, the rest fire once per rising edge
	assign setEv = (reqAll & LEVEL) | (reqAll & ~reqD_r & ~LEVEL);

	always_comb begin
		flags_nxt = flags_r;
		if (wrNow && ap_r.addr == `CBD_A_FLAG) begin
			flags_nxt = hwdata[NSRC-1:0];
		end
		if (takeNow && AUTOCLR[selNum]) begin
			flags_nxt[selNum] = 1'b0;
		end
		flags_nxt = flags_nxt | setEv;
	end

	always_ff @(posedge clk_sys or posedge rst) begin
		if (rst) begin
			flags_r <= '0;
		end else begin
			flags_r <= flags_nxt;
		end
	end

	// =====================================================
	// dispatch
	logic [NSRC-1:0] pend;
	logic [NSRC-1:0] hiPend;
	logic [NSRC-1:0] candidates;
	logic selHi;
	logic canTake;
	logic retiNow;

	assign pend = flags_r & en_r & {NSRC{gen_r}};
	assign hiPend = pend & prio_r;
	assign selHi = |hiPend;
	assign candidates = selHi ? hiPend : pend;

	always_comb begin
		selNum = '0;
		for (int i = NSRC - 1; i >= 0; i--) begin
			if (candidates[i]) begin
				selNum = 5'(i);
			end
		end
	end

	assign canTake = (|pend) && (selHi ? !inSvc_r[1] : (inSvc_r == 2'b00));
	assign takeNow = cpuIn.boundary && canTake && !irqCall_r;
	assign retiNow = cpuIn.opValid && (cpuIn.opcode == `CBD_OP_RETURN_FROM_IRQ);

	always_ff @(posedge clk_sys or posedge rst) begin
		if (rst) begin
			irqCall_r <= 1'b0;
			irqVector_r <= '0;
			irqNum_r <= '0;
		end else begin
			irqCall_r <= takeNow;
			if (takeNow) begin
				irqNum_r <= selNum;
				irqVector_r <= (16'(selNum) << `CBD_VEC_SHIFT) + `CBD_VEC_BASE;
			end
		end
	end

	always_ff @(posedge clk_sys or posedge rst) begin
		if (rst) begin
			inSvc_r <= 2'b00;
		end else if (takeNow) begin
			inSvc_r[selHi] <= 1'b1;
		end else if (retiNow) begin
			if (inSvc_r[1]) begin
				inSvc_r[1] <= 1'b0;
			end else begin
				inSvc_r[0] <= 1'b0;
			end
		end
	end

	assign irqCall = irqCall_r;
	assign irqVector = irqVector_r;
	assign irqNum = irqNum_r;

	// =====================================================
	// instruction decode
	function automatic cbd_pkg::cbd_dec_t decode(input cbd_pkg::cbd_cpu_t c);
		cbd_pkg::cbd_dec_t d;
		logic [7:0] dm1;
		d = '0;
		{d.len, d.cyc} = {2'h1, 3'h1};
		d.known = 1'b1;
		dm1 = c.opA - 8'h01;
		casez (c.opcode)
			`CBD_OP_JBC: begin
				{d.len, d.cyc} = {2'h3, 3'h4};
				d.jump = c.bitIn;
				d.bitWr = c.bitIn;
			end
			`CBD_OP_COMPARE_JUMP_NOT_EQUAL_D, `CBD_OP_COMPARE_JUMP_NOT_EQUAL_I, `CBD_OP_COMPARE_JUMP_NOT_EQUAL_R, `CBD_OP_COMPARE_JUMP_NOT_EQUAL_N: begin
				{d.len, d.cyc} = {2'h3, 3'h4};
				d.jump = (c.opA != c.opB);
				d.cyWr = 1'b1;
				d.cyVal = (c.opA < c.opB);
			end
			`CBD_OP_DECREMENT_JUMP_NONZERO_R: begin
				{d.len, d.cyc} = {2'h2, 3'h3};
				d.jump = (dm1 != 8'h00);
			end
			`CBD_OP_DECREMENT_JUMP_NONZERO_D: begin
				{d.len, d.cyc} = {2'h3, 3'h4};
				d.jump = (dm1 != 8'h00);
			end
			`CBD_OP_JZ, `CBD_OP_JNZ: begin
				{d.len, d.cyc} = {2'h2, 3'h3};
				d.jump = (c.acc == 8'h00) ^ c.opcode[4];
			end
			`CBD_OP_JC, `CBD_OP_JNC: begin
				{d.len, d.cyc} = {2'h2, 3'h3};
				d.jump = c.carry ^ c.opcode[4];
			end
			`CBD_OP_JB, `CBD_OP_JNB: begin
				{d.len, d.cyc} = {2'h3, 3'h4};
				d.jump = c.bitIn ^ c.opcode[4];
			end
			`CBD_OP_JMPI: begin
				{d.len, d.cyc} = {2'h1, 3'h2};
				d.jump = 1'b1;
			end
			`CBD_OP_ANLC, `CBD_OP_ANLCN: begin
				{d.len, d.cyc} = {2'h2, 3'h2};
				d.cyWr = 1'b1;
				d.cyVal = c.carry & (c.bitIn ^ c.opcode[5]);
			end
			`CBD_OP_ORLC, `CBD_OP_ORLCN: begin
				{d.len, d.cyc} = {2'h2, 3'h2};
				d.cyWr = 1'b1;
				d.cyVal = c.carry | (c.bitIn ^ c.opcode[7]);
			end
			`CBD_OP_MOVCB: begin
				{d.len, d.cyc} = {2'h2, 3'h2};
				d.cyWr = 1'b1;
				d.cyVal = c.bitIn;
			end
			`CBD_OP_MOVBC: begin
				{d.len, d.cyc} = {2'h2, 3'h3};
				d.bitWr = 1'b1;
				d.bitVal = c.carry;
			end
			`CBD_OP_LONG_CALL: begin
				{d.len, d.cyc} = {2'h3, 3'h6};
				d.jump = 1'b1;
			end
			`CBD_OP_ABSOLUTE_CALL: begin
				{d.len, d.cyc} = {2'h2, 3'h6};
				d.jump = 1'b1;
			end
			`CBD_OP_AJMP, `CBD_OP_SJMP: begin
				{d.len, d.cyc} = {2'h2, 3'h3};
				d.jump = 1'b1;
			end
			`CBD_OP_LJMP: begin
				{d.len, d.cyc} = {2'h3, 3'h4};
				d.jump = 1'b1;
			end
			`CBD_OP_RET, `CBD_OP_RETURN_FROM_IRQ: begin
				{d.len, d.cyc} = {2'h1, 3'h4};
				d.jump = 1'b1;
				d.retIrq = c.opcode[4];
			end
			`CBD_OP_CLRC, `CBD_OP_SETC, `CBD_OP_CPLC: begin
				d.cyWr = 1'b1;
				d.cyVal = c.opcode[5] ? ~c.carry : c.opcode[4];
			end
			`CBD_OP_CLRB, `CBD_OP_SETB, `CBD_OP_CPLB: begin
				{d.len, d.cyc} = {2'h2, 3'h3};
				d.bitWr = 1'b1;
				d.bitVal = c.opcode[5] ? ~c.bitIn : c.opcode[4];
			end
			`CBD_OP_NOP: d.known = 1'b1;
			default: d.known = 1'b0;
		endcase
		// flag effects of the arithmetic group
		if (c.opcode[3:2] != 2'b00 && (c.opcode[7:4] == `CBD_HI_ADD || c.opcode[7:4] == `CBD_HI_ADDC
				|| c.opcode[7:4] == `CBD_HI_SUBB)) begin
			{d.cyWr, d.cyAlu, d.ovWr, d.acWr} = 4'hf;
		end
		if (c.opcode == `CBD_OP_MUL || c.opcode == `CBD_OP_DIV) begin
			{d.cyWr, d.cyVal, d.ovWr} = 3'b101;
		end
		if (c.opcode == `CBD_OP_DA || c.opcode == `CBD_OP_RRC || c.opcode == `CBD_OP_RLC) begin
			{d.cyWr, d.cyAlu} = 2'b11;
		end
		return d;
	endfunction

	always_ff @(posedge clk_sys or posedge rst) begin
		if (rst) begin
			decOut <= '0;
			decValid <= 1'b0;
		end else begin
			decValid <= cpuIn.opValid;
			if (cpuIn.opValid) begin
				decOut <= decode(cpuIn);
			end
		end
	end

	// =====================================================
	// checks
	default clocking cb @(posedge clk_sys); endclocking
	default disable iff (rst);

	sequence s_take;
		cpuIn.boundary && canTake && !irqCall_r;
	endsequence
	sequence s_ackAuto;
		takeNow && AUTOCLR[selNum] && !setEv[selNum];
	endsequence
	sequence s_op(logic [7:0] code);
		cpuIn.opValid && cpuIn.opcode == code;
	endsequence

	a_flag_set: assert property ((setEv != '0) |=> ((flags_r & $past(setEv)) == $past(setEv)))
		else $error("request flag not set by event");
	a_port_level: assert property (reqAll[13] |=> flags_r[13])
		else $error("level source flag dropped");
	a_one_shot: assert property (wrNow && ap_r.addr == `CBD_A_FLAG && (reqAll & reqD_r & ~LEVEL & ~hwdata[NSRC-1:0]) != '0
			|=> (flags_r & $past(reqAll & reqD_r & ~LEVEL & ~hwdata[NSRC-1:0])) == '0)
		else $error("one-shot source set twice");
	a_evt_merge: assert property (reqAll[9] == |(evtReq[7:4] & evMask_r[7:4]))
		else $error("event mask merge wrong");
	a_global_gate: assert property (irqCall_r |-> $past(gen_r) && (($past(en_r) >> irqNum_r) & 18'h1) != '0)
		else $error("call taken while disabled");
	a_vector_addr: assert property (irqCall_r |-> irqVector_r == 16'(irqNum_r) * 16'h0008 + 16'h0003)
		else $error("vector address wrong");
	a_call_next: assert property (s_take |=> irqCall_r ##1 !irqCall_r)
		else $error("forced call not issued next cycle");
	a_auto_clear: assert property (s_ackAuto |=> !flags_r[$past(selNum)])
		else $error("auto-clear flag survived entry");
	a_flag_keep: assert property (takeNow && !AUTOCLR[selNum] && !wrNow |=> flags_r[$past(selNum)])
		else $error("non auto-clear flag lost");
	a_preempt: assert property (irqCall_r |-> !$past(inSvc_r[1])
			&& ($past(inSvc_r) == 2'b00 || (($past(prio_r) >> irqNum_r) & 18'h1) != '0))
		else $error("preemption by equal or lower priority");
	a_return_from_irq_pop: assert property (retiNow && inSvc_r[1] && !takeNow |=> !inSvc_r[1] && inSvc_r[0] == $past(inSvc_r[0]))
		else $error("return did not end active level");
	a_jbc_shape: assert property (s_op(`CBD_OP_JBC) |=> decOut.len == 2'h3 && decOut.cyc == 3'h4
			&& decOut.jump == decOut.bitWr && !decOut.bitVal)
		else $error("bit jump-and-clear decode wrong");
	a_compare_jump_not_equal_dir: assert property (s_op(`CBD_OP_COMPARE_JUMP_NOT_EQUAL_D) |=> decOut.len == 2'h3 && decOut.cyc == 3'h4
			&& decOut.jump == ($past(cpuIn.opA) != $past(cpuIn.opB)) && decOut.cyWr)
		else $error("compare jump decode wrong");
	a_decrement_jump_nonzero_dir: assert property (s_op(`CBD_OP_DECREMENT_JUMP_NONZERO_D) |=> decOut.len == 2'h3 && decOut.cyc == 3'h4
			&& decOut.jump == ($past(cpuIn.opA) != 8'h01))
		else $error("decrement jump decode wrong");
	a_jnz_acc: assert property (s_op(`CBD_OP_JNZ) |=> decOut.len == 2'h2 && decOut.cyc == 3'h3
			&& decOut.jump == ($past(cpuIn.acc) != 8'h00))
		else $error("accumulator jump decode wrong");
	a_jc_carry: assert property (s_op(`CBD_OP_JC) |=> decOut.len == 2'h2 && decOut.jump == $past(cpuIn.carry))
		else $error("carry jump decode wrong");
	a_jnb_bit: assert property (s_op(`CBD_OP_JNB) |=> decOut.cyc == 3'h4 && decOut.jump == !$past(cpuIn.bitIn))
		else $error("bit jump decode wrong");
	a_jmp_ind: assert property (s_op(`CBD_OP_JMPI) |=> decOut.len == 2'h1 && decOut.cyc == 3'h2 && decOut.jump)
		else $error("indirect jump decode wrong");
	a_anl_not: assert property (s_op(`CBD_OP_ANLCN) |=> decOut.cyVal == ($past(cpuIn.carry) & !$past(cpuIn.bitIn)))
		else $error("and complement into carry wrong");
	a_orl_bit: assert property (s_op(`CBD_OP_ORLC) |=> decOut.cyVal == ($past(cpuIn.carry) | $past(cpuIn.bitIn)))
		else $error("or bit into carry wrong");
	a_mov_bit: assert property (s_op(`CBD_OP_MOVBC) |=> decOut.cyc == 3'h3 && decOut.bitWr
			&& decOut.bitVal == $past(cpuIn.carry))
		else $error("carry to bit move wrong");
	a_mul_flags: assert property (s_op(`CBD_OP_MUL) |=> decOut.cyWr && !decOut.cyVal && decOut.ovWr && !decOut.acWr)
		else $error("multiply flag effects wrong");
endmodule

// File: verif/cbd_src_model.sv
// peripheral request sources facing the dispatch block
`timescale 1ns/1ns
module cbd_src_model (
	input wire logic clk_sys,
	input wire logic rst,
	input wire logic fire,
	input wire logic [4:0] fireSrc,
	input wire logic [1:0] fireEvt,
	input wire logic [31:0] levelEvt,
	output logic [17:0] srcReq,
	output logic [31:0] evtReq
);
	logic [17:0] srcPulse_r;
	logic [31:0] evtPulse_r;

	// =====================================
	// group of a multi-event source, -1 if none
	function automatic int grp(input logic [4:0] s);
		int map [8] = '{6, 9, 10, 11, 12, 13, 15, 16};
		grp = -1;
		for (int g = 0; g < 8; g++) begin
			if (map[g] == int'(s)) grp = g;
		end
	endfunction

	// =====================================
	// one-shot events
	always_ff @(posedge clk_sys or posedge rst) begin
		if (rst) begin
			srcPulse_r <= 18'h0;
			evtPulse_r <= 32'h0;
		end else begin
			srcPulse_r <= 18'h0;
			evtPulse_r <= 32'h0;
			if (fire && grp(fireSrc) >= 0) begin
				evtPulse_r[grp(fireSrc) * 4 + int'(fireEvt)] <= 1'b1;
			end else if (fire) begin
				srcPulse_r[fireSrc] <= 1'b1;
			end
		end
	end

	// port conditions stay until cleared at the source
	assign srcReq = srcPulse_r;
	assign evtReq = evtPulse_r | levelEvt;
endmodule

// File: verif/cbd_dispatch_test.sv
// self-checking bench for the branch, boolean and interrupt dispatch block
`timescale 1ns/1ns
module cbd_dispatch_test;
	logic clk_sys = 1'b0;
	logic rst = 1'b1;
	logic hsel = 1'b0;
	logic [31:0] haddr = 32'h0;
	logic [1:0] htrans = 2'h0;
	logic hwrite = 1'b0;
	logic [2:0] hsize = 3'h2;
	logic [31:0] hwdata = 32'h0;
	logic hreadyout, hresp, irqCall, decValid, hwClr;
	logic [31:0] hrdata, rd, evtReq;
	logic [15:0] irqVector;
	logic [4:0] irqNum;
	logic [17:0] srcReq;
	cbd_pkg::cbd_dec_t decOut;
	cbd_pkg::cbd_cpu_t cpu = '0;
	logic fire = 1'b0;
	logic [4:0] fireSrc = 5'h0;
	logic [1:0] fireEvt = 2'h0;
	logic [31:0] levelEvt = 32'h0;
	logic [7:0] compare_jump_not_equal [6] = '{8'hb5, 8'hb4, 8'hb8, 8'hbf, 8'hb6, 8'hb7};
	int fails = 0;
	int n_checks = 0;
	int cycles = 0;

	always #50 clk_sys = ~clk_sys;

	cbd_dispatch i_cbd_dispatch (.clk_sys(clk_sys), .rst(rst), .hsel(hsel), .haddr(haddr), .htrans(htrans),
		.hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hreadyout), .hreadyout(hreadyout),
		.hresp(hresp), .hrdata(hrdata), .srcReq(srcReq), .evtReq(evtReq), .cpuIn(cpu), .irqCall(irqCall),
		.irqVector(irqVector), .irqNum(irqNum), .decValid(decValid), .decOut(decOut));

	cbd_src_model i_cbd_src_model (.clk_sys(clk_sys), .rst(rst), .fire(fire), .fireSrc(fireSrc),
		.fireEvt(fireEvt), .levelEvt(levelEvt), .srcReq(srcReq), .evtReq(evtReq));

	// =====================================
	// checking and closing
	task automatic check(input logic [31:0] seen, input logic [31:0] exp);
		n_checks++;
		if (seen !== exp) begin
			fails++;
			$display("CHECK FAILED at %0t: seen %h expected %h", $time, seen, exp);
		end
	endtask

	task automatic report_and_stop();
		$display("checks %0d, mismatches %0d", n_checks, fails);
		if (fails == 0 && n_checks > 0) begin
			$display("verification passed");
		end else begin
			$display("verification failed");
		end
		$finish;
	endtask

	always @(posedge clk_sys) begin
		cycles++;
		if (cycles == 10000) begin
			fails++;
			report_and_stop();
		end
	end

	// =====================================
	// bus master, single word transfers
	task automatic wait_ready();
		logic r;
		do begin
			@(negedge clk_sys);
			r = hreadyout;
			rd = hrdata;
			@(posedge clk_sys);
		end while (r !== 1'b1);
	endtask

	task automatic bus(input logic [7:0] a, input logic w, input logic [31:0] d);
		@(posedge clk_sys);
		hsel <= 1'b1;
		htrans <= 2'h2;
		haddr <= {24'h0, a};
		hwrite <= w;
		wait_ready();
		hsel <= 1'b0;
		htrans <= 2'h0;
		hwdata <= d;
		wait_ready();
	endtask

	task automatic rdchk(input logic [7:0] a, input logic [31:0] exp);
		bus(a, 1'b0, 32'h0);
		check(rd, exp);
		check({31'h0, hresp}, 32'h0);
	endtask

	// =====================================
	// cpu side: decode requests, boundaries, source events
	task automatic dec(input logic [7:0] op, input logic [7:0] acc, input logic [1:0] cb, input logic [7:0] a,
			input logic [7:0] b, input logic [1:0] l, input logic [2:0] c, input logic [8:0] f, input logic cyx);
		cbd_pkg::cbd_dec_t e;
		logic [14:0] m;
		e = cbd_pkg::cbd_dec_t'({l, c, 1'b1, f});
		// arithmetic group: flag effects only, not decoded as known
		e.known = !(op inside {8'h13, 8'h33, 8'h34, 8'h84, 8'h94, 8'ha4, 8'hd4});
		m = 15'h7fff;
		if (cyx || e.cyAlu) m[6:5] = 2'h0;
		if (!e.bitWr) m[1] = 1'b0;
		@(posedge clk_sys);
		cpu.opValid <= 1'b1;
		cpu.opcode <= op;
		cpu.acc <= acc;
		{cpu.carry, cpu.bitIn} <= cb;
		cpu.opA <= a;
		cpu.opB <= b;
		@(posedge clk_sys);
		cpu.opValid <= 1'b0;
		#1;
		check({31'h0, decValid}, 32'h1);
		check({17'h0, decOut & m}, {17'h0, e & m});
	endtask

	task automatic return_from_irq();
		dec(8'h32, 8'h0, 2'h0, 8'h0, 8'h0, 2'h1, 3'h4, 9'h101, 1'b0);
	endtask

	task automatic boundary(input logic take, input logic [4:0] n);
		@(posedge clk_sys);
		cpu.boundary <= 1'b1;
		@(posedge clk_sys);
		cpu.boundary <= 1'b0;
		#1;
		check({31'h0, irqCall}, {31'h0, take});
		if (take) begin
			check({16'h0, irqVector}, 32'(n) * 32'h8 + 32'h3);
			check({27'h0, irqNum}, {27'h0, n});
		end
		@(posedge clk_sys);
		#1;
		check({31'h0, irqCall}, 32'h0);
	endtask

	task automatic pulse_src(input logic [4:0] s, input logic [1:0] ev);
		@(posedge clk_sys);
		fire <= 1'b1;
		fireSrc <= s;
		fireEvt <= ev;
		@(posedge clk_sys);
		fire <= 1'b0;
		repeat (2) @(posedge clk_sys);
	endtask

	// =====================================
	// tests
	initial begin
		repeat (12) @(posedge clk_sys);
		rst <= 1'b0;
		for (int a = 0; a < 8; a++) rdchk(8'(a * 4), 32'h0);
		bus(8'h00, 1'b1, 32'h3ffff);
		rdchk(8'h00, 32'h3ffff);
		bus(8'h04, 1'b1, 32'hff);
		rdchk(8'h04, 32'hbf);
		bus(8'h08, 1'b1, 32'hff);
		rdchk(8'h08, 32'h3f);
		bus(8'h0c, 1'b1, 32'hff);
		rdchk(8'h0c, 32'h3f);
		bus(8'h1c, 1'b1, 32'hff);
		rdchk(8'h1c, 32'h0);
		for (int a = 0; a < 4; a++) bus(8'(a * 4), 1'b1, 32'h0);
		$display("test registers done");

		dec(8'h10, 8'h0, 2'h1, 8'h0, 8'h0, 2'h3, 3'h4, 9'h104, 1'b0);
		dec(8'h10, 8'h0, 2'h0, 8'h0, 8'h0, 2'h3, 3'h4, 9'h000, 1'b0);
		foreach (compare_jump_not_equal[i]) dec(compare_jump_not_equal[i], 8'h0, 2'h0, 8'h5, 8'h3, 2'h3, 3'h4, 9'h180, 1'b1);
		dec(8'hb5, 8'h0, 2'h0, 8'h3, 8'h3, 2'h3, 3'h4, 9'h080, 1'b1);
		dec(8'hd8, 8'h0, 2'h0, 8'h2, 8'h0, 2'h2, 3'h3, 9'h100, 1'b0);
		dec(8'hdf, 8'h0, 2'h0, 8'h2, 8'h0, 2'h2, 3'h3, 9'h100, 1'b0);
		dec(8'hd5, 8'h0, 2'h0, 8'h1, 8'h0, 2'h3, 3'h4, 9'h000, 1'b0);
		dec(8'h60, 8'h0, 2'h0, 8'h0, 8'h0, 2'h2, 3'h3, 9'h100, 1'b0);
		dec(8'h70, 8'h0, 2'h0, 8'h0, 8'h0, 2'h2, 3'h3, 9'h000, 1'b0);
		dec(8'h40, 8'h0, 2'h2, 8'h0, 8'h0, 2'h2, 3'h3, 9'h100, 1'b0);
		dec(8'h50, 8'h0, 2'h2, 8'h0, 8'h0, 2'h2, 3'h3, 9'h000, 1'b0);
		dec(8'h20, 8'h0, 2'h1, 8'h0, 8'h0, 2'h3, 3'h4, 9'h100, 1'b0);
		dec(8'h30, 8'h0, 2'h1, 8'h0, 8'h0, 2'h3, 3'h4, 9'h000, 1'b0);
		dec(8'h73, 8'h0, 2'h0, 8'h0, 8'h0, 2'h1, 3'h2, 9'h100, 1'b0);
		dec(8'h82, 8'h0, 2'h2, 8'h0, 8'h0, 2'h2, 3'h2, 9'h080, 1'b0);
		dec(8'hb0, 8'h0, 2'h2, 8'h0, 8'h0, 2'h2, 3'h2, 9'h0a0, 1'b0);
		dec(8'h72, 8'h0, 2'h1, 8'h0, 8'h0, 2'h2, 3'h2, 9'h0a0, 1'b0);
		dec(8'ha0, 8'h0, 2'h1, 8'h0, 8'h0, 2'h2, 3'h2, 9'h080, 1'b0);
		dec(8'ha2, 8'h0, 2'h1, 8'h0, 8'h0, 2'h2, 3'h2, 9'h0a0, 1'b0);
		dec(8'h92, 8'h0, 2'h2, 8'h0, 8'h0, 2'h2, 3'h3, 9'h006, 1'b0);
		dec(8'hd3, 8'h0, 2'h0, 8'h0, 8'h0, 2'h1, 3'h1, 9'h0a0, 1'b0);
		dec(8'hc3, 8'h0, 2'h2, 8'h0, 8'h0, 2'h1, 3'h1, 9'h080, 1'b0);
		dec(8'hb3, 8'h0, 2'h2, 8'h0, 8'h0, 2'h1, 3'h1, 9'h080, 1'b0);
		dec(8'ha4, 8'h0, 2'h2, 8'h0, 8'h0, 2'h1, 3'h1, 9'h090, 1'b0);
		dec(8'h84, 8'h0, 2'h2, 8'h0, 8'h0, 2'h1, 3'h1, 9'h090, 1'b0);
		dec(8'hd4, 8'h0, 2'h0, 8'h0, 8'h0, 2'h1, 3'h1, 9'h0c0, 1'b0);
		dec(8'h13, 8'h0, 2'h0, 8'h0, 8'h0, 2'h1, 3'h1, 9'h0c0, 1'b0);
		dec(8'h33, 8'h0, 2'h0, 8'h0, 8'h0, 2'h1, 3'h1, 9'h0c0, 1'b0);
		dec(8'h34, 8'h0, 2'h0, 8'h0, 8'h0, 2'h1, 3'h1, 9'h0d8, 1'b0);
		dec(8'h94, 8'h0, 2'h0, 8'h0, 8'h0, 2'h1, 3'h1, 9'h0d8, 1'b0);
		return_from_irq();
		$display("test decoder done");

		bus(8'h04, 1'b1, 32'h02);
		pulse_src(5'h05, 2'h0);
		pulse_src(5'h01, 2'h0);
		rdchk(8'h00, 32'h22);
		boundary(1'b0, 5'h0);
		bus(8'h04, 1'b1, 32'h92);
		boundary(1'b1, 5'h01);
		rdchk(8'h00, 32'h20);
		pulse_src(5'h04, 2'h0);
		boundary(1'b0, 5'h0);
		return_from_irq();
		boundary(1'b1, 5'h04);
		rdchk(8'h00, 32'h30);
		bus(8'h10, 1'b1, 32'h20000);
		bus(8'h0c, 1'b1, 32'h20);
		pulse_src(5'h11, 2'h0);
		boundary(1'b1, 5'h11);
		rdchk(8'h18, 32'h47);
		return_from_irq();
		return_from_irq();
		for (int a = 0; a < 5; a++) bus(8'(a * 4), 1'b1, 32'h0);
		$display("test dispatch done");

		bus(8'h14, 1'b1, 32'h20);
		pulse_src(5'h09, 2'h0);
		rdchk(8'h00, 32'h0);
		pulse_src(5'h09, 2'h1);
		rdchk(8'h00, 32'h200);
		bus(8'h14, 1'b1, 32'hf00020);
		// port 0 held, timer 1 event held too: only the port re-arms
		levelEvt <= 32'h100020;
		bus(8'h00, 1'b1, 32'h0);
		rdchk(8'h00, 32'h2000);
		levelEvt <= 32'h0;
		bus(8'h00, 1'b1, 32'h0);
		rdchk(8'h00, 32'h0);
		bus(8'h14, 1'b1, 32'h0);
		$display("test level and masks done");

		bus(8'h04, 1'b1, 32'hbf);
		bus(8'h08, 1'b1, 32'h3f);
		bus(8'h0c, 1'b1, 32'h3f);
		for (int n = 0; n < 18; n++) begin
			hwClr = n inside {[0:3], [9:12]};
			bus(8'h00, 1'b1, 32'h1 << n);
			boundary(1'b1, 5'(n));
			rdchk(8'h00, hwClr ? 32'h0 : 32'h1 << n);
			bus(8'h00, 1'b1, 32'h0);
			return_from_irq();
		end
		$display("test vectors done");
		report_and_stop();
	end
endmodule
